// file: bench/kli_keys_model.sv
/*
  Key matrix model: one pressed key pulls its port-one line low.
  Assumes a pull-up on every line, so a released key reads high.
*/
module kli_keys_model
(
  // Key state from the bench.
  input  wire logic [7:0] pressed,
  // Port-one lines.
  output logic [7:0]      lines
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released lines go to the pull-up level, never to a held value.
  assign lines = ~pressed;
endmodule

// file: bench/kli_top_test.sv
/*
  Self-checking bench for the keyboard level interrupt unit.
  Assumes the key matrix model on port one and the core side driven here.
*/
module kli_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import kli_pkg::*;

  logic            ref_clk   = 1'b0;
  logic            reset     = 1'b1;
  logic            glob      = 1'b0;
  logic            idle_e    = 1'b0;
  logic            pdown_e   = 1'b0;
  kli_sfr_req_type req       = '0;
  logic [7:0]      pressed   = 8'h00;
  logic [7:0]      port_one;
  logic [7:0]      rdata;
  logic [7:0]      alt;
  logic            hit;
  logic            irq;
  logic            wake;
  int              fail_count = 0;
  int              cmp_count  = 0;

  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  kli_keys_model keys (.pressed(pressed), .lines(port_one));

  kli_top dut (.ref_clk(ref_clk), .reset(reset), .sfr_req(req), .sfr_rdata(rdata), .sfr_hit(hit),
    .port_one(port_one), .key_irq_global_enable(glob), .idle_enter(idle_e), .pdown_enter(pdown_e),
    .key_irq(irq), .wake_request(wake), .key_alt_select(alt));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Requests are made at the falling edge; the answer is read one cycle later.
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q,
                     output logic h);
    @(negedge ref_clk);
    req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge ref_clk);
    q = rdata;
    h = hit;
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       h;
    bus(a, 1'b1, d, q, h);
    chk(8'(h), 8'h01, "write hit");
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hexp);
    logic [7:0] q;
    logic       h;
    bus(a, 1'b0, 8'h00, q, h);
    chk(q, exp, "read data");
    chk(8'(h), 8'(hexp), "read hit");
  endtask

  // Pin to flag to request takes three edges.
  task automatic settle;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic t_reset;
    rd(8'h9C, 8'h00, 1'b1);
    rd(8'h9D, 8'h00, 1'b1);
    rd(8'h9E, 8'h00, 1'b1);
    rd(8'h9F, 8'h00, 1'b0);
    chk(alt, 8'h00, "alt select");
  endtask

  task automatic t_low;
    wr(8'h9D, 8'h01);
    glob = 1'b1;
    pressed = 8'h01;
    settle;
    rd(8'h9E, 8'h01, 1'b1);
    chk(8'(irq), 8'h01, "irq");
    chk(alt, 8'h01, "alt select");
    pressed = 8'h00;
    settle;
    rd(8'h9E, 8'h01, 1'b1);
    wr(8'h9E, 8'hFE);
    repeat (2) @(negedge ref_clk);
    chk(8'(irq), 8'h00, "irq after clear");
    rd(8'h9E, 8'h00, 1'b1);
  endtask

  task automatic t_mask;
    pressed = 8'h02;
    settle;
    rd(8'h9E, 8'h02, 1'b1);
    chk(8'(irq), 8'h00, "masked irq");
    glob = 1'b0;
    pressed = 8'h03;
    settle;
    rd(8'h9E, 8'h03, 1'b1);
    chk(8'(irq), 8'h00, "global off irq");
    pressed = 8'h00;
    wr(8'h9E, 8'h00);
    rd(8'h9E, 8'h00, 1'b1);
  endtask

  task automatic t_persist;
    glob = 1'b1;
    pressed = 8'h01;
    settle;
    wr(8'h9E, 8'hFE);
    rd(8'h9E, 8'h01, 1'b1);
    chk(8'(irq), 8'h01, "irq kept");
    pressed = 8'h00;
    wr(8'h9E, 8'h00);
    glob = 1'b0;
  endtask

  task automatic t_high;
    for (int n = 0; n < 8; n++)
    begin
      wr(8'h9C, 8'h01 << n);
      settle;
      rd(8'h9E, 8'h01 << n, 1'b1);
      wr(8'h9C, 8'h00);
      wr(8'h9E, 8'h00);
    end
    rd(8'h9E, 8'h00, 1'b1);
  endtask

  // Wake must work with the global enable off.
  task automatic t_wake;
    int wakes;
    for (int m = 0; m < 2; m++)
    begin
      wakes = 0;
      @(negedge ref_clk);
      idle_e = (m == 0);
      pdown_e = (m == 1);
      @(negedge ref_clk);
      idle_e = 1'b0;
      pdown_e = 1'b0;
      pressed = 8'h01;
      // The wake pulse stands one cycle, so each falling edge sees it at most once.
      repeat (8)
      begin
        @(negedge ref_clk);
        if (wake === 1'b1)
          wakes++;
      end
      chk(8'(wakes), 8'h01, "wake count");
      chk(8'(irq), 8'h00, "irq with global off");
      pressed = 8'h00;
      wr(8'h9E, 8'h00);
    end
  endtask

  // A reset in mid-run must drop a pending flag, the configuration and the request.
  task automatic t_midreset;
    wr(8'h9D, 8'hFF);
    wr(8'h9C, 8'h80);
    glob = 1'b1;
    settle;
    chk(8'(irq), 8'h01, "irq before reset");
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    t_reset;
    chk(8'(irq), 8'h00, "irq after reset");
    glob = 1'b0;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #200us;
    fail_count++;
    test_done;
  end

  initial
  begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    t_reset;
    t_low;
    t_mask;
    t_persist;
    t_high;
    t_wake;
    t_midreset;
    test_done;
  end
endmodule

// file: src/kli_line.sv
/*
  One keyboard line: synchronous pin sample, level compare and sticky flag.
  Assumes the pin is synchronous to ref_clk and that the parent decodes clears.
*/
module kli_line
(
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset,
  // Line.
  input  wire logic pin,
  input  wire logic level_high,
  input  wire logic flag_clear,
  output logic      flag,
  output logic      match
);
  import kli_pkg::*;

  logic pin_q;
  logic next_flag;

  assign match     = (pin_q == level_high);           // [R1] [R14]
  assign next_flag = match | (flag & ~flag_clear);    // [R5] [R7] [R15]

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      // The sample starts at the released, pulled-up level; a low start value would
      // match the reset low-level select and raise a false flag right after reset.
      pin_q <= 1'b1;
      flag  <= 1'b0;  // [R12]
    end
    else
    begin
      pin_q <= pin;
      flag  <= next_flag;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // A level seen on the pin must be in the flag two edges later.
  a_flag_follows_level: assert property ((pin == level_high) ##1 $stable(level_high) |=> flag) // [R5]
    else $error("flag not set by programmed level");
  a_flag_stays_set: assert property (flag && !flag_clear |=> flag) // [R7]
    else $error("flag dropped without a clear");
  a_clear_then_rearm: assert property (flag_clear && match |=> flag) // [R15]
    else $error("flag not set again while level persists");

endmodule

// file: src/kli_pkg.sv
/*
  Constants and carrier types for the keyboard level interrupt unit.
  Assumes a byte-wide special function register bus driven by the core.
*/
package kli_pkg;

  localparam int KLI_LINES = 8;

  // Special function register addresses.
  localparam logic [7:0] KLI_LEVEL_ADDR  = 8'h9C;
  localparam logic [7:0] KLI_ENABLE_ADDR = 8'h9D;
  localparam logic [7:0] KLI_FLAG_ADDR   = 8'h9E;

  // Reset values.
  localparam logic [7:0] KLI_LEVEL_RST  = 8'h00;
  localparam logic [7:0] KLI_ENABLE_RST = 8'h00;
  localparam logic [7:0] KLI_FLAG_RST   = 8'h00;
  localparam logic [7:0] KLI_RDATA_RST  = 8'h00;
  localparam logic [7:0] KLI_UNMAPPED   = 8'h00;

  // Pin sampling stages ahead of the flag.
  localparam int KLI_SAMPLE_STAGES = 1;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } kli_sfr_req_type;

  // Gray along run/idle and run/power-down.
  typedef enum logic [1:0] {
    KLI_RUN   = 2'b00,
    KLI_IDLE  = 2'b01,
    KLI_PDOWN = 2'b10
  } kli_power_type;

endpackage

// file: src/kli_top.sv
/*
  Keyboard level interrupt unit: eight port-one lines, level select, per-line
  enable, sticky flags, one shared interrupt request and a wake request.
  Assumes the core drives the byte-wide register bus synchronously to ref_clk,
  owns the global keyboard enable and signals entry into idle or power-down.
*/
// Notes on behaviour
// [R1] Eight port-one inputs, each detecting a high or low level per select bit.
// [R2] All eight lines are separate sources sharing one interrupt request.
// [R3] The global keyboard enable gates the combined request; clear means none.
// [R4] Each detection is recorded in its line flag, masked by its enable bit; the code sets the flag regardless and the enable masks only the request.
// [R5] Flag n sets when line n shows its programmed level.
// [R6] A flag requests only while its enable bit is set; otherwise recorded only.
// [R7] Flags stay set until software clears them; hardware never clears them.
// [R8] An enabled qualifying level wakes the device from idle and power-down.
// [R9] Lines not used as keyboard inputs stay free for ordinary port use.
// [R10] The flag register sits at address 9Eh, bit n for line n.
// [R11] The enable register sits at address 9Dh, bit n for line n.
// [R12] The flag register reads all zeros after reset.
// [R13] Enable clear gives a plain pin; set lets the flag interrupt; resets zero.
// [R14] Level-select at 9Ch: zero detects low, one detects high; resets zero.
// [R15] Inputs sampled on the clock; a persisting level sets the flag again.
module kli_top
(
  // Clock and reset.
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // Register bus from the core.
  input  wire kli_pkg::kli_sfr_req_type sfr_req,
  output logic [7:0]                    sfr_rdata,
  output logic                          sfr_hit,
  // Port one and core controls.
  input  wire logic [7:0]               port_one,
  input  wire logic                     key_irq_global_enable,
  input  wire logic                     idle_enter,
  input  wire logic                     pdown_enter,
  // To the core and the port.
  output logic                          key_irq,
  output logic                          wake_request,
  output logic [7:0]                    key_alt_select
);
  import kli_pkg::*;

  logic [7:0]    key_level_select;
  logic [7:0]    key_enable_reg;
  logic [7:0]    key_flag_reg;
  logic [7:0]    line_match;
  kli_power_type power_state;
  kli_power_type next_power_state;

  // Address decode.
  wire sel_level  = (sfr_req.addr == KLI_LEVEL_ADDR);   // [R14]
  wire sel_enable = (sfr_req.addr == KLI_ENABLE_ADDR);  // [R11]
  wire sel_flag   = (sfr_req.addr == KLI_FLAG_ADDR);    // [R10]
  wire sel_any    = sel_level | sel_enable | sel_flag;

  wire wr_level  = sfr_req.wr & sel_level;
  wire wr_enable = sfr_req.wr & sel_enable;
  wire wr_flag   = sfr_req.wr & sel_flag;

  // Writing a zero to a flag bit clears it; a one leaves it alone, so
  // software cannot fake a key event.
  wire [7:0] flag_clear = wr_flag ? ~sfr_req.wdata : 8'h00;  // [R7]

  // Read selection.
  wire [7:0] read_value = sel_level  ? key_level_select :
                          sel_enable ? key_enable_reg   :
                          sel_flag   ? key_flag_reg     :
                                       KLI_UNMAPPED;

  // Request and wake terms.
  // Wake ignores the global enable so that a masked core can still be woken.
  wire [7:0] pending     = key_flag_reg & key_enable_reg;       // [R4] [R6]
  wire       any_pending = |pending;                            // [R2]
  wire       next_irq    = any_pending & key_irq_global_enable; // [R3]
  wire       asleep      = (power_state != KLI_RUN);
  wire       next_wake   = asleep & any_pending;                // [R8]

  // Per-line detection.
  genvar g;
  generate
    for (g = 0; g < KLI_LINES; g = g + 1)
    begin : gen_line
      kli_line u_line
      (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .pin        (port_one[g]),
        .level_high (key_level_select[g]),
        .flag_clear (flag_clear[g]),
        .flag       (key_flag_reg[g]),
        .match      (line_match[g])
      );
    end
  endgenerate

  // Configuration registers.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      key_level_select <= KLI_LEVEL_RST;   // [R14]
      key_enable_reg   <= KLI_ENABLE_RST;  // [R13]
    end
    else
    begin
      if (wr_level)
        key_level_select <= sfr_req.wdata;
      if (wr_enable)
        key_enable_reg <= sfr_req.wdata;
    end
  end

  // Read data is held until the next mapped or unmapped read.
  // The hit pulse lets the core tell a mapped access from a refused one.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sfr_rdata <= KLI_RDATA_RST;
      sfr_hit   <= 1'b0;
    end
    else
    begin
      if (sfr_req.rd)
        sfr_rdata <= read_value;
      sfr_hit <= (sfr_req.rd | sfr_req.wr) & sel_any;
    end
  end

  // The enable bit hands the pin to the keyboard; cleared lines stay ordinary
  // port pins because this unit never drives port one.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      key_alt_select <= KLI_ENABLE_RST;
    else
      key_alt_select <= key_enable_reg;  // [R9] [R13]
  end

  // Reduced-activity tracking.
  // An enabled flag still pending on entry wakes the unit again at once, so
  // software must clear serviced flags before it sleeps.
  always_comb
  begin
    next_power_state = power_state;
    case (power_state)
      KLI_RUN:
      begin
        if (pdown_enter)
          next_power_state = KLI_PDOWN;
        else if (idle_enter)
          next_power_state = KLI_IDLE;
      end
      KLI_IDLE:
      begin
        if (any_pending)
          next_power_state = KLI_RUN;  // [R8]
      end
      KLI_PDOWN:
      begin
        if (any_pending)
          next_power_state = KLI_RUN;  // [R8]
      end
      default:
        next_power_state = KLI_RUN;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      power_state  <= KLI_RUN;
      key_irq      <= 1'b0;
      wake_request <= 1'b0;
    end
    else
    begin
      power_state  <= next_power_state;
      key_irq      <= next_irq;   // [R2] [R3] [R6]
      wake_request <= next_wake;  // [R8]
    end
  end

  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_global_gate_off: assert property (!key_irq_global_enable |=> !key_irq) // [R3]
    else $error("interrupt raised with global enable clear");

  a_irq_needs_enabled: assert property (key_irq |-> $past(|(key_flag_reg & key_enable_reg))) // [R6]
    else $error("interrupt raised without an enabled flag");

  a_irq_from_flag: assert property (|(key_flag_reg & key_enable_reg) && key_irq_global_enable |=> key_irq) // [R4]
    else $error("enabled flag did not raise the interrupt");

  a_masked_flag_kept: assert property (key_flag_reg[1] && !key_enable_reg[1] && !wr_flag |=> key_flag_reg[1]) // [R6]
    else $error("masked flag was not kept");

  a_wake_from_sleep: assert property (asleep && any_pending |=> wake_request && power_state == KLI_RUN) // [R8]
    else $error("enabled level did not wake the device");

  a_flag_read_back: assert property (sfr_req.rd && sel_flag |=> sfr_rdata == $past(key_flag_reg)) // [R10]
    else $error("flag register read wrong");

  a_enable_read_back: assert property (sfr_req.rd && sel_enable |=> sfr_rdata == $past(key_enable_reg)) // [R11]
    else $error("enable register read wrong");

  a_level_read_back: assert property (sfr_req.rd && sel_level |=> sfr_rdata == $past(key_level_select)) // [R14]
    else $error("level register read wrong");

  a_flags_after_reset: assert property (disable iff (1'b0) $past(reset) && !reset |-> key_flag_reg == KLI_FLAG_RST) // [R12]
    else $error("flags not clear after reset");

  a_config_after_reset: assert property (disable iff (1'b0)
    $past(reset) && !reset |-> key_enable_reg == KLI_ENABLE_RST && key_level_select == KLI_LEVEL_RST) // [R13]
    else $error("configuration not clear after reset");

  a_no_self_clear: assert property (key_flag_reg[7] && !wr_flag |=> key_flag_reg[7]) // [R7]
    else $error("flag cleared by hardware");

  // Register bus: writes land at the next edge, unmapped accesses are refused.
  a_level_write_lands: assert property (wr_level |=> key_level_select == $past(sfr_req.wdata)) // [R14]
    else $error("level select write did not land");

  a_enable_write_lands: assert property (wr_enable |=> key_enable_reg == $past(sfr_req.wdata)) // [R11]
    else $error("enable write did not land");

  a_config_kept: assert property (!wr_level && !wr_enable // [R13]
    |=> $stable(key_level_select) && $stable(key_enable_reg))
    else $error("configuration changed without a write");

  a_mapped_hit: assert property ((sfr_req.rd || sfr_req.wr) && sel_any |=> sfr_hit) // [R10] [R11]
    else $error("mapped access gave no hit");

  a_unmapped_no_hit: assert property ((sfr_req.rd || sfr_req.wr) && !sel_any |=> !sfr_hit) // [R10]
    else $error("unmapped access gave a hit");

  a_idle_bus_no_hit: assert property (!sfr_req.rd && !sfr_req.wr |=> !sfr_hit) // [R10]
    else $error("hit without an access");

  a_hit_pulse: assert property (sfr_hit |-> $past(sfr_req.rd || sfr_req.wr)) // [R10]
    else $error("hit not caused by an access");

  a_unmapped_reads_zero: assert property (sfr_req.rd && !sel_any |=> sfr_rdata == KLI_UNMAPPED) // [R10]
    else $error("unmapped read not zero");

  a_rdata_held: assert property (!sfr_req.rd |=> $stable(sfr_rdata)) // [R10]
    else $error("read data changed without a read");

  // Flag register: a zero clears a flag unless its level is present that cycle.
  a_flag_cleared: assert property (wr_flag && !sfr_req.wdata[0] && !line_match[0] |=> !key_flag_reg[0]) // [R7]
    else $error("written zero did not clear the flag");

  a_set_beats_clear: assert property (wr_flag && !sfr_req.wdata[0] && line_match[0] |=> key_flag_reg[0]) // [R15]
    else $error("clear won over a present level");

  a_flag_needs_level: assert property (!key_flag_reg[0] && !line_match[0] |=> !key_flag_reg[0]) // [R5]
    else $error("flag set without its level");

  // Interrupt request: needs an enabled flag and the global enable.
  a_irq_drops: assert property (!any_pending |=> !key_irq) // [R6]
    else $error("interrupt kept without a pending flag");

  a_irq_needs_global: assert property (key_irq |-> $past(key_irq_global_enable)) // [R3]
    else $error("interrupt raised without the global enable");

  a_all_masked_quiet: assert property (!(|key_enable_reg) |=> !key_irq) // [R6] [R13]
    else $error("interrupt raised with every line masked");

  // Reduced activity: entry, hold and a single wake pulse.
  a_idle_entry: assert property (!asleep && idle_enter && !pdown_enter |=> power_state == KLI_IDLE) // [R8]
    else $error("idle entry missed");

  a_pdown_wins: assert property (!asleep && pdown_enter |=> power_state == KLI_PDOWN) // [R8]
    else $error("power-down entry missed");

  a_sleep_holds: assert property (asleep && !any_pending // [R8]
    |=> power_state == $past(power_state) && !wake_request)
    else $error("left sleep without a pending flag");

  a_no_wake_awake: assert property (!asleep |=> !wake_request) // [R8]
    else $error("wake pulse while running");

  a_wake_needs_flag: assert property (wake_request |-> $past(any_pending)) // [R8]
    else $error("wake without an enabled flag");

  a_wake_lands_run: assert property (wake_request |-> power_state == KLI_RUN) // [R8]
    else $error("wake pulse left the unit asleep");

  a_alt_follows_enable: assert property (1'b1 |=> key_alt_select == $past(key_enable_reg)) // [R9] [R13]
    else $error("alternate select does not follow the enable register");

  c_irq_raised:      cover property (!key_irq ##1 key_irq);
  c_wake_pdown:      cover property (power_state == KLI_PDOWN ##1 wake_request);
  c_wake_idle:       cover property (power_state == KLI_IDLE ##1 wake_request);
  c_clear_and_rearm: cover property (wr_flag && key_flag_reg[0] ##1 key_flag_reg[0]);
  c_high_level_line: cover property (key_level_select[3] && key_flag_reg[3]);

endmodule
